//--- gdfm_top.sv
// Purpose: protection and diagnostics manager for an H-bridge gate driver
// Assumes: comparator inputs already compare against the level outputs
// Notes: all pins pass a three-flop synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Driver-off pin forces all gate pull-downs
// - Gates stay off until enable bit set
// - Fault clear clears latches, self-resets
// - Logic-supply low or sleep makes block inactive
// - Power-on-reset bit held until fault clear
// - Supply undervoltage: pull-downs, pump off, report
// - Latched undervoltage holds until fault clear
// - Auto undervoltage recovers; flag stays sticky
// - Overvoltage uses selected level and deglitch
// - Overvoltage latched or auto fault response
// - Overvoltage warn only reports; off ignores
// - Pump undervoltage: pull-downs and report
// - Latched pump undervoltage also stops pump
// - Auto pump undervoltage recovers; flag sticky
// - Overcurrent after selected level and deglitch
// - Independent shutdown in bridge modes 00, 11
// - Latched overcurrent holds until fault clear
// - Cycle overcurrent cleared by next PWM edge
// - Overcurrent warn only reports, sticky
// - Overcurrent off mode ignores comparators
// - Overcurrent uses dedicated sink strength
module gdfm_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Avalon-MM slave
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Control pins
  input wire logic DRIVER_OFF,
  input wire logic SLEEP_N,
  input wire logic [1:0] PWM_IN,
  // Monitor comparators
  input wire logic LOGIC_LOW,
  input wire logic SUPPLY_UNDER,
  input wire logic SUPPLY_OVER,
  input wire logic PUMP_UNDER,
  input wire logic [3:0] DS_OVER,
  // Driver controls
  output logic [1:0] PULL_DOWN,
  output logic [3:0] SINK_STRENGTH,
  output logic PUMP_ENABLE,
  output logic MONITOR_ENABLE,
  output logic SUPPLY_OVER_LEVEL,
  output logic PUMP_UNDER_LEVEL,
  output logic [3:0] DS_LEVEL,
  // Open-drain fault output
  output logic FAULT_OUT_N_O,
  output logic FAULT_OUT_N_OE
);
  import gdfm_pkg::*;

  localparam int NIN = 12;
  localparam int NSRC = 8;

  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] sync3;
  logic [NIN-1:0] filt;
  logic drv_off;
  logic sleep_n;
  logic [1:0] pwm;
  logic [1:0] pwm_q;
  logic pwm_edge;
  logic [NSRC-1:0] src;
  logic [NSRC-1:0] det;
  logic [DG_W-1:0] lim [NSRC];
  logic [DG_W-1:0] cnt [NSRC];
  logic inactive;
  logic [31:0] ctrl;
  logic [31:0] cfg;
  logic [31:0] rd_val;
  logic [31:0] wmask;
  logic gate_en;
  logic clr;
  logic split;
  logic uv_auto;
  logic cp_auto;
  gdfm_ov_t ov_mode;
  gdfm_ds_t ds_mode;
  logic uv_st;
  logic ov_st;
  logic cp_st;
  logic [3:0] ds_st;
  logic uv_flag;
  logic ov_flag;
  logic cp_flag;
  logic [3:0] ds_flag;
  logic warn;
  logic por_bit;
  logic summary;
  logic glob_pd;

  function automatic logic [DG_W-1:0] dg_sel(input logic [1:0] sel);
    case (sel)
      2'h0: dg_sel = DG_OPT0_CYC;
      2'h1: dg_sel = DG_OPT1_CYC;
      2'h2: dg_sel = DG_OPT2_CYC;
      default: dg_sel = DG_OPT3_CYC;
    endcase
  endfunction : dg_sel

  // Pin synchroniser; a change counts once stages two and three agree
  assign raw_in = {DS_OVER, PUMP_UNDER, SUPPLY_OVER, SUPPLY_UNDER,
                   LOGIC_LOW, PWM_IN, SLEEP_N, DRIVER_OFF};
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  for (genvar i = 0; i < NIN; i++) begin : g_filt
    always_ff @(posedge CLK) begin
      if (RESET) begin
        filt[i] <= 1'b0;
      end else if (sync2[i] == sync3[i]) begin
        filt[i] <= sync3[i];
      end
    end
  end

  assign drv_off = filt[0];
  assign sleep_n = filt[1];
  assign pwm = filt[3:2];
  assign pwm_edge = |(pwm ^ pwm_q);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pwm_q <= '0;
    end else begin
      pwm_q <= pwm;
    end
  end

  assign inactive = det[0] | ~sleep_n;

  // Field extraction
  assign gate_en = ctrl[CTL_EN];
  assign clr = ctrl[CTL_CLR];
  assign split = ctrl[CTL_IND] &&
                 (ctrl[CTL_BRG+:2] == BRG_INDEP ||
                  ctrl[CTL_BRG+:2] == BRG_SPLIT);
  assign uv_auto = cfg[CFG_UV_AUTO];
  assign cp_auto = cfg[CFG_CP_AUTO];
  assign ov_mode = gdfm_ov_t'(cfg[CFG_OV_MODE+:2]);
  assign ds_mode = gdfm_ds_t'(cfg[CFG_DS_MODE+:2]);

  assign src = {filt[11:8], filt[7], filt[6], filt[5], filt[4]};
  assign lim[0] = POR_DG_CYC;
  assign lim[1] = UV_DG_CYC;
  assign lim[2] = dg_sel(cfg[CFG_OV_DG+:2]);
  assign lim[3] = CP_DG_CYC;
  for (genvar i = 4; i < NSRC; i++) begin : g_lim
    assign lim[i] = dg_sel(cfg[CFG_DS_DG+:2]);
  end

  // Deglitch; monitors other than the logic supply stop when inactive
  for (genvar i = 0; i < NSRC; i++) begin : g_dg
    always_ff @(posedge CLK) begin
      if (RESET) begin
        cnt[i] <= '0;
        det[i] <= 1'b0;
      end else if (!src[i] || (i != 0 && inactive)) begin
        cnt[i] <= '0;
        det[i] <= 1'b0;
      end else if (cnt[i] >= lim[i]) begin
        det[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 1'b1;
      end
    end
  end

  // Avalon-MM: one wait cycle, then the request completes
  always_ff @(posedge CLK) begin
    if (RESET) begin
      WAITREQUEST <= 1'b1;
    end else if ((READ || WRITE) && WAITREQUEST) begin
      WAITREQUEST <= 1'b0;
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b+:8] = {8{BYTEENABLE[b]}};
    end
  end

  always_comb begin
    if (ADDRESS == ADDR_CTRL) begin
      rd_val = ctrl;
    end else if (ADDRESS == ADDR_CFG) begin
      rd_val = cfg;
    end else if (ADDRESS == ADDR_STAT) begin
      rd_val = {22'h0, ds_flag, cp_flag, ov_flag, uv_flag,
                por_bit, warn, summary};
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && WAITREQUEST) begin
      READDATA <= rd_val;
    end
  end

  // fault clear drops one cycle after it is written
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl <= CTRL_RST;
    end else if (WRITE && !WAITREQUEST && ADDRESS == ADDR_CTRL) begin
      ctrl <= ((ctrl & ~wmask) | (WRITEDATA & wmask)) & CTRL_MASK;
    end else begin
      ctrl[CTL_CLR] <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg <= CFG_RST;
    end else if (WRITE && !WAITREQUEST && ADDRESS == ADDR_CFG) begin
      cfg <= ((cfg & ~wmask) | (WRITEDATA & wmask)) & CFG_MASK;
    end
  end

  // a clear while the condition stands has no effect
  always_ff @(posedge CLK) begin
    if (RESET) begin
      por_bit <= 1'b1;
    end else if (det[0]) begin
      por_bit <= 1'b1;
    end else if (clr) begin
      por_bit <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      uv_st <= 1'b0;
      uv_flag <= 1'b0;
    end else begin
      if (det[1]) begin
        uv_st <= 1'b1;
      end else if (uv_auto || clr) begin
        uv_st <= 1'b0;
      end
      if (det[1]) begin
        uv_flag <= 1'b1;
      end else if (clr) begin
        uv_flag <= 1'b0;
      end
    end
  end

  // overvoltage fault in latched or auto mode
  // warn mode never faults; off mode never reports
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ov_st <= 1'b0;
      ov_flag <= 1'b0;
    end else begin
      if (ov_mode == OV_WARN || ov_mode == OV_OFF) begin
        ov_st <= 1'b0;
      end else if (det[2]) begin
        ov_st <= 1'b1;
      end else if (ov_mode == OV_AUTO || clr) begin
        ov_st <= 1'b0;
      end
      if (det[2] && ov_mode != OV_OFF) begin
        ov_flag <= 1'b1;
      end else if (clr) begin
        ov_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cp_st <= 1'b0;
      cp_flag <= 1'b0;
    end else begin
      if (det[3]) begin
        cp_st <= 1'b1;
      end else if (cp_auto || clr) begin
        cp_st <= 1'b0;
      end
      if (det[3]) begin
        cp_flag <= 1'b1;
      end else if (clr) begin
        cp_flag <= 1'b0;
      end
    end
  end

  // Overcurrent per FET: HS1, LS1, HS2, LS2
  for (genvar i = 0; i < 4; i++) begin : g_ds
    always_ff @(posedge CLK) begin
      if (RESET) begin
        ds_st[i] <= 1'b0;
        ds_flag[i] <= 1'b0;
      end else begin
        if (ds_mode == DS_WARN || ds_mode == DS_OFF) begin
          ds_st[i] <= 1'b0;
        end else if (det[4+i]) begin
          ds_st[i] <= 1'b1;
        end else if (ds_mode == DS_LATCH && clr) begin
          ds_st[i] <= 1'b0;
        end else if (ds_mode == DS_CYCLE && pwm_edge) begin
          ds_st[i] <= 1'b0;
        end
        // warn and fault modes set the flag
        if (det[4+i] && ds_mode != DS_OFF) begin
          ds_flag[i] <= 1'b1;
        end else if (clr) begin
          ds_flag[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      warn <= 1'b0;
    end else if ((det[2] && ov_mode == OV_WARN) ||
                 (|det[7:4] && ds_mode == DS_WARN)) begin
      warn <= 1'b1;
    end else if (clr) begin
      warn <= 1'b0;
    end
  end

  // summary from every standing fault state
  assign summary = uv_st | ov_st | cp_st | (|ds_st);
  assign glob_pd = drv_off | ~gate_en | inactive | uv_st | ov_st |
                   cp_st | (~split & (|ds_st));

  // Outputs registered; pull-downs default on after reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PULL_DOWN <= 2'h3;
      PUMP_ENABLE <= 1'b0;
      MONITOR_ENABLE <= 1'b0;
      FAULT_OUT_N_O <= 1'b0;
      FAULT_OUT_N_OE <= 1'b0;
    end else begin
      // only the faulty half-bridge when split
      PULL_DOWN[0] <= glob_pd | ds_st[0] | ds_st[1];
      PULL_DOWN[1] <= glob_pd | ds_st[2] | ds_st[3];
      // latched pump fault keeps pump off
      PUMP_ENABLE <= ~inactive & ~uv_st & ~(cp_st & ~cp_auto);
      MONITOR_ENABLE <= ~inactive;
      FAULT_OUT_N_O <= 1'b0;
      FAULT_OUT_N_OE <= summary;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      SINK_STRENGTH <= 4'h0;
      SUPPLY_OVER_LEVEL <= 1'b0;
      PUMP_UNDER_LEVEL <= 1'b0;
      DS_LEVEL <= 4'h0;
    end else begin
      SINK_STRENGTH <= (|ds_st) ? cfg[CFG_DS_SINK+:4] : cfg[CFG_SINK+:4];
      SUPPLY_OVER_LEVEL <= cfg[CFG_OV_LVL];
      PUMP_UNDER_LEVEL <= cfg[CFG_CP_LVL];
      DS_LEVEL <= cfg[CFG_DS_LVL+:4];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  drv_off_pd_a: assert property (drv_off |=> PULL_DOWN == 2'h3)
    else $error("driver off did not pull gates down");
  gate_en_a: assert property (!gate_en |=> PULL_DOWN == 2'h3)
    else $error("gates driven while enable is low");
  clr_self_a: assert property (clr |=> !clr)
    else $error("fault clear did not self-reset");
  sleep_off_a: assert property (inactive |=> !PUMP_ENABLE
    && !MONITOR_ENABLE && PULL_DOWN == 2'h3)
    else $error("inactive state not honoured");
  por_hold_a: assert property (por_bit && !clr |=> por_bit)
    else $error("power-on-reset bit dropped early");
  uv_resp_a: assert property (uv_st |=> FAULT_OUT_N_OE
    && !PUMP_ENABLE && PULL_DOWN == 2'h3)
    else $error("undervoltage response missing");
  uv_latch_a: assert property (uv_st && !uv_auto && !clr |=> uv_st)
    else $error("latched undervoltage released");
  uv_auto_a: assert property (uv_st && uv_auto && !det[1]
    |=> !uv_st ##1 (PUMP_ENABLE || $past(inactive)
    || ($past(cp_st) && !$past(cp_auto))))
    else $error("auto undervoltage did not recover");
  ov_warn_a: assert property (det[2] && ov_mode == OV_WARN
    |=> warn && ov_flag && !ov_st)
    else $error("overvoltage warn mode misbehaved");
  cp_latch_a: assert property (cp_st && !cp_auto |=> !PUMP_ENABLE)
    else $error("latched pump fault left pump on");
  ds_cycle_a: assert property (ds_mode == DS_CYCLE && pwm_edge
    && det[7:4] == 4'h0 |=> ds_st == 4'h0)
    else $error("cycle mode not cleared by PWM edge");
  ds_off_a: assert property (ds_mode == DS_OFF && !clr
    |=> ds_st == 4'h0 && ds_flag == $past(ds_flag))
    else $error("disabled overcurrent reacted");
  sink_sel_a: assert property (|ds_st
    |=> SINK_STRENGTH == $past(cfg[CFG_DS_SINK+:4]))
    else $error("overcurrent sink strength not applied");
  summary_a: assert property (summary |=> FAULT_OUT_N_OE)
    else $error("fault output not asserted");

  uv_auto_c: cover property (uv_st && uv_auto ##[1:20] !uv_st);
  ov_latch_c: cover property (ov_st && ov_mode == OV_LATCH ##1 clr);
  ds_cycle_c: cover property (ds_st != 4'h0 ##[1:50] pwm_edge);
  split_c: cover property (split && ds_st[2] && PULL_DOWN == 2'h2);
endmodule : gdfm_top

`default_nettype wire

//--- gdfm_pkg.sv
// Purpose: constants and types for the gate driver fault manager
// Assumes: 100 MHz core clock, Avalon-MM register access
// Notes: byte addresses, one 32-bit word per register
package gdfm_pkg;
  // Clock and deglitch times (ns)
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_DG_NS = 10000;
  localparam int UV_DG_NS = 10000;
  localparam int CP_DG_NS = 10000;
  localparam int DG_OPT0_NS = 1000;
  localparam int DG_OPT1_NS = 2000;
  localparam int DG_OPT2_NS = 4000;
  localparam int DG_OPT3_NS = 8000;
  localparam int DG_W = 10;
  localparam logic [DG_W-1:0] POR_DG_CYC =
    DG_W'((POR_DG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_W-1:0] UV_DG_CYC =
    DG_W'((UV_DG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_W-1:0] CP_DG_CYC =
    DG_W'((CP_DG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_W-1:0] DG_OPT0_CYC =
    DG_W'((DG_OPT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_W-1:0] DG_OPT1_CYC =
    DG_W'((DG_OPT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_W-1:0] DG_OPT2_CYC =
    DG_W'((DG_OPT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_W-1:0] DG_OPT3_CYC =
    DG_W'((DG_OPT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  // Reset values and writable masks
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0037;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0FF3_F7FF;
  // Control fields
  localparam int CTL_EN = 0;
  localparam int CTL_CLR = 1;
  localparam int CTL_IND = 2;
  localparam int CTL_BRG = 4;
  // Configuration fields
  localparam int CFG_UV_AUTO = 0;
  localparam int CFG_CP_AUTO = 1;
  localparam int CFG_OV_MODE = 2;
  localparam int CFG_DS_MODE = 4;
  localparam int CFG_OV_LVL = 6;
  localparam int CFG_OV_DG = 8;
  localparam int CFG_CP_LVL = 10;
  localparam int CFG_DS_LVL = 12;
  localparam int CFG_DS_DG = 16;
  localparam int CFG_DS_SINK = 20;
  localparam int CFG_SINK = 24;
  // Bridge modes allowing per half-bridge shutdown
  localparam logic [1:0] BRG_INDEP = 2'h0;
  localparam logic [1:0] BRG_SPLIT = 2'h3;
  typedef enum logic [1:0] {OV_LATCH, OV_AUTO, OV_WARN, OV_OFF} gdfm_ov_t;
  typedef enum logic [1:0] {DS_LATCH, DS_CYCLE, DS_WARN, DS_OFF} gdfm_ds_t;
endpackage : gdfm_pkg

//--- gdfm_plant.sv
// Purpose: far-side model of the sensed power stage
// Assumes: shares the core clock with the bench
// Notes: a short only trips while its half-bridge still drives
`timescale 1ns/1ps
`default_nettype none
module gdfm_plant (
  // Clock
  input wire logic clk,
  // Commanded conditions: [3:0] shorts, [4] uv, [5] ov, [6] pump uv
  input wire logic [6:0] cond,
  // Gate state seen from the stage
  input wire logic [1:0] pull_down,
  // Comparator lines
  output logic [3:0] ds_over,
  output logic supply_under,
  output logic supply_over,
  output logic pump_under
);
  logic [3:0] on_mask;
  assign on_mask = ~{pull_down[1], pull_down[1], pull_down[0], pull_down[0]};
  initial begin
    ds_over = 4'h0;
    supply_under = 1'b0;
    supply_over = 1'b0;
    pump_under = 1'b0;
  end
  // no drain-source drop once the gate is pulled down
  always @(posedge clk) begin
    ds_over <= cond[3:0] & on_mask;
    supply_under <= cond[4];
    supply_over <= cond[5];
    pump_under <= cond[6];
  end
endmodule : gdfm_plant
`default_nettype wire

//--- gdfm_top_bench.sv
// Purpose: register-level regression of the fault manager
// Assumes: one core clock, monitors idle unless commanded
// Notes: fixed waits follow the deglitch figures of the hand-over
`timescale 1ns/1ps
`default_nettype none
module gdfm_top_bench;
  import gdfm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic driver_off = 1'b0;
  logic sleep_n = 1'b1;
  logic logic_low = 1'b0;
  logic [1:0] pwm_in = 2'h0;
  logic [6:0] cond = 7'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, pump_enable, monitor_enable, fault_o, fault_oe;
  logic su, so, pu;
  logic [3:0] ds_over, sink_strength;
  logic [1:0] pull_down;
  logic ov_lvl, cp_lvl;
  logic [3:0] ds_lvl;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  gdfm_top gdfm_top_inst (
    .CLK(clk), .RESET(reset), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
    .READDATA(readdata), .WAITREQUEST(waitrequest),
    .DRIVER_OFF(driver_off), .SLEEP_N(sleep_n), .PWM_IN(pwm_in),
    .LOGIC_LOW(logic_low), .SUPPLY_UNDER(su), .SUPPLY_OVER(so),
    .PUMP_UNDER(pu), .DS_OVER(ds_over), .PULL_DOWN(pull_down),
    .SINK_STRENGTH(sink_strength), .PUMP_ENABLE(pump_enable),
    .MONITOR_ENABLE(monitor_enable), .SUPPLY_OVER_LEVEL(ov_lvl),
    .PUMP_UNDER_LEVEL(cp_lvl), .DS_LEVEL(ds_lvl), .FAULT_OUT_N_O(fault_o),
    .FAULT_OUT_N_OE(fault_oe)
  );
  gdfm_plant gdfm_plant_inst (
    .clk(clk), .cond(cond), .pull_down(pull_down), .ds_over(ds_over),
    .supply_under(su), .supply_over(so), .pump_under(pu)
  );

  always #5 clk = ~clk;

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, far above the roughly 15k cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // Request stands until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask : rdchk

  function automatic logic [31:0] outs();
    return {29'h0, fault_oe, &pull_down, pump_enable};
  endfunction : outs

  // One fault episode: raise, check, remove, check, clear
  task automatic episode(input int b, input logic [31:0] cfg, input int dly,
      input logic pw, input logic [9:0] ds, input logic [2:0] dv,
      input logic [9:0] as, input logic [2:0] av);
    wr(ADDR_CFG, cfg);
    wr(ADDR_CTRL, 32'h0000_0003);
    cond[b] <= 1'b1;
    hold(dly);
    rdchk(ADDR_STAT, {22'h0, ds});
    check(outs(), {29'h0, dv});
    check({28'h0, sink_strength}, {28'h0, (b < 4 && dv[2]) ?
          cfg[CFG_DS_SINK+:4] : cfg[CFG_SINK+:4]});
    cond[b] <= 1'b0;
    hold(dly + 50);
    if (pw) begin
      check({31'h0, fault_oe}, 32'h1);
      pwm_in <= ~pwm_in;
      hold(20);
    end
    rdchk(ADDR_STAT, {22'h0, as});
    check(outs(), {29'h0, av});
    wr(ADDR_CTRL, 32'h0000_0003);
    hold(5);
    rdchk(ADDR_STAT, 32'h0);
    check(outs(), 32'h1);
  endtask : episode

  initial begin
    hold(10);
    reset <= 1'b0;
    hold(10);
    rdchk(ADDR_STAT, 32'h4);
    check({30'h0, pull_down}, 32'h3);
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_CFG, CFG_RST);
    bus(1'b1, ADDR_CFG, 32'hFFFF_FFFF, 4'h1);
    rdchk(ADDR_CFG, 32'hFF & CFG_MASK);
    check({25'h0, ov_lvl, cp_lvl, ds_lvl, fault_o}, 32'h40);
    wr(ADDR_CFG, 32'hFFFF_FFFF);
    rdchk(ADDR_CFG, CFG_MASK);
    check({25'h0, ov_lvl, cp_lvl, ds_lvl, fault_o}, 32'h7E);
    wr(4'hC, 32'hFFFF_FFFF);
    rdchk(4'hC, 32'h0);
    wr(ADDR_STAT, 32'hFFFF_FFFF);
    rdchk(ADDR_STAT, 32'h4);
    wr(ADDR_CTRL, 32'h0000_0003);
    hold(3);
    rdchk(ADDR_CTRL, 32'h1);
    rdchk(ADDR_STAT, 32'h0);
    check({30'h0, pull_down}, 32'h0);
    driver_off <= 1'b1;
    hold(10);
    check({30'h0, pull_down}, 32'h3);
    driver_off <= 1'b0;
    hold(10);
    check({30'h0, pull_down}, 32'h0);
    $display("test registers and enables done");
    episode(4, 32'h0, 1030, 1'b0, 10'h009, 3'b110, 10'h009, 3'b110);
    episode(4, 32'h1, 1030, 1'b0, 10'h009, 3'b110, 10'h008, 3'b001);
    episode(6, 32'h0, 1030, 1'b0, 10'h021, 3'b110, 10'h021, 3'b110);
    episode(6, 32'h2, 1030, 1'b0, 10'h021, 3'b111, 10'h020, 3'b001);
    $display("test undervoltage done");
    episode(5, 32'h0, 130, 1'b0, 10'h011, 3'b111, 10'h011, 3'b111);
    episode(5, 32'h4, 130, 1'b0, 10'h011, 3'b111, 10'h010, 3'b001);
    episode(5, 32'h8, 130, 1'b0, 10'h012, 3'b001, 10'h012, 3'b001);
    episode(5, 32'hC, 130, 1'b0, 10'h000, 3'b001, 10'h000, 3'b001);
    wr(ADDR_CFG, 32'h0000_0100);
    cond[5] <= 1'b1;
    hold(150);
    check({31'h0, fault_oe}, 32'h0);
    hold(80);
    check({31'h0, fault_oe}, 32'h1);
    cond[5] <= 1'b0;
    hold(250);
    wr(ADDR_CTRL, 32'h0000_0003);
    $display("test overvoltage done");
    episode(2, 32'h0A50_0000, 130, 1'b0, 10'h101, 3'b111,
            10'h101, 3'b111);
    episode(2, 32'h0A50_0010, 130, 1'b1, 10'h101, 3'b111,
            10'h100, 3'b001);
    episode(2, 32'h0A50_0020, 130, 1'b0, 10'h102, 3'b001,
            10'h102, 3'b001);
    episode(2, 32'h0A50_0030, 130, 1'b0, 10'h000, 3'b001,
            10'h000, 3'b001);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CFG, 32'h0);
      wr(ADDR_CTRL, 32'h7 | (32'(m) << 4));
      cond[2] <= 1'b1;
      hold(130);
      check({30'h0, pull_down}, (m == 0 || m == 3) ? 32'h2 : 32'h3);
      rdchk(ADDR_STAT, 32'h101);
      cond[2] <= 1'b0;
      hold(150);
      wr(ADDR_CTRL, 32'h0000_0003);
    end
    // Second overcurrent deglitch choice, 200 cycles
    wr(ADDR_CFG, 32'h0001_0000);
    cond[0] <= 1'b1;
    hold(150);
    check({31'h0, fault_oe}, 32'h0);
    hold(80);
    check({31'h0, fault_oe}, 32'h1);
    cond[0] <= 1'b0;
    hold(150);
    wr(ADDR_CTRL, 32'h0000_0003);
    $display("test overcurrent done");
    sleep_n <= 1'b0;
    hold(10);
    check({29'h0, monitor_enable, pump_enable, &pull_down}, 32'h1);
    sleep_n <= 1'b1;
    hold(10);
    check({29'h0, monitor_enable, pump_enable, &pull_down}, 32'h6);
    logic_low <= 1'b1;
    hold(1030);
    check({31'h0, monitor_enable}, 32'h0);
    logic_low <= 1'b0;
    hold(20);
    check({31'h0, monitor_enable}, 32'h1);
    rdchk(ADDR_STAT, 32'h4);
    $display("test inactive states done");
    wrap_up();
  end
endmodule : gdfm_top_bench
`default_nettype wire
